// file: jip_pkg.sv
// Summary of operation
// - The port pins carry JTAG whenever a pin strap, a PLD term or the software enable bit is true.
// - With the dedicated-pin strap the JTAG pins stay in JTAG use at all times.
// - In the shared arrangement a dedicated PLD input pin reclaims the pins for programming at any moment.
// - The software enable bit is cleared by every device reset, dropping that source.
// - The progress and fault pins are enabled only together and only by a scan command.
// - The fault pin is driven low when a sector erase or byte program fails.
// - The progress pin is 1 in read mode and 0 while a program or erase runs.
// - Progress and fault pins are each open-drain by default or push-pull by choice.
// - A blank part has all config bits at 0 and its four JTAG pins ready for programming.
// - With the combined enable false the four JTAG pins act as general I/O.
// - No boundary scan exists; the part always stays in bypass inside a chain.
package jip_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] REG_CTRL  = 2'h0;
    localparam logic [1:0] REG_STAT  = 2'h1;
    localparam logic [1:0] REG_MASK  = 2'h2;
    localparam logic [1:0] REG_STATE = 2'h3;

    localparam int CTRL_JTAG_EN  = 0;
    localparam int CTRL_PROG_PP  = 1;
    localparam int CTRL_FAULT_PP = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    localparam int ST_JTAG_UP = 0;
    localparam int ST_EXT_CHG = 1;
    localparam int ST_FAULT   = 2;
    localparam int ST_DONE    = 3;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    // ------------------------------------------------------------
    // Scan instructions
    // ------------------------------------------------------------
    localparam logic [3:0] IR_BYPASS  = 4'hF;
    localparam logic [3:0] IR_EXT_ON  = 4'h5;
    localparam logic [3:0] IR_EXT_OFF = 4'h6;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // ------------------------------------------------------------
    // Bit positions of sampled pins and general I/O lanes
    // ------------------------------------------------------------
    localparam int SY_TCK     = 0;
    localparam int SY_TMS     = 1;
    localparam int SY_TDI     = 2;
    localparam int SY_RECLAIM = 3;

    localparam int GP_TMS   = 0;
    localparam int GP_TCK   = 1;
    localparam int GP_PROG  = 2;
    localparam int GP_FAULT = 3;
    localparam int GP_TDI   = 4;
    localparam int GP_TDO   = 5;

    localparam int EX_PROG  = 0;
    localparam int EX_FAULT = 1;

    // Idle levels of the sampled pins, so reset leaves no false edge
    localparam logic [3:0] SYNC_RST = 4'hA;

    // ------------------------------------------------------------
    // Scan controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET  = 16'h0001,
        TAP_IDLE   = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR  = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR  = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PAU_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } jip_tap_e;

endpackage

// file: jip_pin_if.sv
`timescale 1ns/100ps
interface jip_pin_if;
    logic [3:0] raw;
    logic [3:0] sync;
    logic [1:0] ext_val;
    logic [1:0] ext_od;
    logic [1:0] ext_en;
    logic [1:0] gp_o;
    logic [1:0] gp_oe;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;

    modport sampler (input raw, output sync);
    modport driver  (input ext_val, ext_od, ext_en, gp_o, gp_oe,
                     output pin_o, pin_oe);
endinterface

// file: jip_sync.sv
`timescale 1ns/100ps
module jip_sync (
    // Clock and reset
    input wire logic  clk,
    input wire logic  rstn,
    // Pins in, sampled levels out
    jip_pin_if.sampler sp
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
    } jip_sync_s;

    jip_sync_s st_q;
    jip_sync_s st_d;

    // Stage one feeds stage two only; metastability settles in between
    always_comb begin
        st_d    = st_q;
        st_d.s1 = sp.raw;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= '{s1: jip_pkg::SYNC_RST, s2: jip_pkg::SYNC_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign sp.sync = st_q.s2;
endmodule

// file: jip_odrv.sv
`timescale 1ns/100ps
module jip_odrv (
    // Extension values and general I/O fallback
    jip_pin_if.driver dp
);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            // Open-drain only ever pulls low, so chained parts can share a wire
            assign dp.pin_oe[g] = dp.ext_en[g] ?
                                  (dp.ext_od[g] ? ~dp.ext_val[g] : 1'b1) :
                                  dp.gp_oe[g];
            assign dp.pin_o[g]  = dp.ext_en[g] ?
                                  (dp.ext_od[g] ? 1'b0 : dp.ext_val[g]) :
                                  dp.gp_o[g];
        end
    endgenerate
endmodule

// file: jip_top.sv
`timescale 1ns/100ps
module jip_top (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    // Enable sources and straps
    input  wire logic       cfg_programmed,
    input  wire logic       cfg_dedicated_jtag,
    input  wire logic       cfg_reclaim_sel,
    input  wire logic       pld_jtag_eq,
    input  wire logic       cable_reclaim_enable_n,
    // Flash engine state
    input  wire logic       flash_busy,
    input  wire logic       flash_error,
    // Port pins
    input  wire logic       port_c_bit0_in,
    output logic            port_c_bit0_out,
    output logic            port_c_bit0_oe,
    input  wire logic       port_c_bit1_in,
    output logic            port_c_bit1_out,
    output logic            port_c_bit1_oe,
    input  wire logic       port_c_bit3_in,
    output logic            port_c_bit3_out,
    output logic            port_c_bit3_oe,
    input  wire logic       port_c_bit4_in,
    output logic            port_c_bit4_out,
    output logic            port_c_bit4_oe,
    input  wire logic       port_c_bit5_in,
    output logic            port_c_bit5_out,
    output logic            port_c_bit5_oe,
    input  wire logic       port_c_bit6_in,
    output logic            port_c_bit6_out,
    output logic            port_c_bit6_oe,
    // General I/O side
    input  wire logic [5:0] gpio_out,
    input  wire logic [5:0] gpio_oe,
    output logic      [5:0] gpio_in,
    // Status
    output logic            jtag_on
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        jip_pkg::jip_tap_e tap;
        logic [3:0]        ir;
        logic [3:0]        ir_sh;
        logic              byp;
        logic              tdo;
        logic              tdo_oe;
        logic              tck_prev;
        logic              ext_en;
        logic [2:0]        ctrl;
        logic [3:0]        stat;
        logic [3:0]        mask;
        logic [7:0]        rdata;
        logic              prog;
        logic              fault;
        logic              busy_prev;
        logic              jtag_prev;
    } jip_core_s;

    localparam jip_core_s CORE_RST = '{
        tap:       jip_pkg::TAP_RESET,
        ir:        jip_pkg::IR_BYPASS,
        ir_sh:     jip_pkg::IR_BYPASS,
        byp:       1'b0,
        tdo:       1'b0,
        tdo_oe:    1'b0,
        tck_prev:  1'b0,
        ext_en:    1'b0,
        ctrl:      jip_pkg::CTRL_RST,
        stat:      jip_pkg::STAT_RST,
        mask:      jip_pkg::MASK_RST,
        rdata:     8'h00,
        prog:      1'b1,
        fault:     1'b0,
        busy_prev: 1'b0,
        jtag_prev: 1'b0
    };

    jip_core_s st_q;
    jip_core_s st_d;

    jip_pin_if p ();

    logic tck_rise;
    logic tck_fall;
    logic ext_active;
    logic reclaim;
    logic [3:0] events;

    // ------------------------------------------------------------
    // Pin sampling and extension drivers
    // ------------------------------------------------------------
    assign p.raw[jip_pkg::SY_TCK]     = port_c_bit1_in;
    assign p.raw[jip_pkg::SY_TMS]     = port_c_bit0_in;
    assign p.raw[jip_pkg::SY_TDI]     = port_c_bit5_in;
    assign p.raw[jip_pkg::SY_RECLAIM] = cable_reclaim_enable_n;

    jip_sync u_sync (
        .clk  (clk),
        .rstn (rstn),
        .sp   (p.sampler)
    );

    jip_odrv u_odrv (
        .dp (p.driver)
    );

    // ------------------------------------------------------------
    // Combined enable
    // ------------------------------------------------------------
    // The cable's enable output lands on the reclaim pin, active low
    assign reclaim = cfg_reclaim_sel & ~p.sync[jip_pkg::SY_RECLAIM];
    assign jtag_on = cfg_dedicated_jtag
                   | pld_jtag_eq
                   | reclaim
                   | st_q.ctrl[jip_pkg::CTRL_JTAG_EN]
                   | ~cfg_programmed;

    assign ext_active = jtag_on & st_q.ext_en;

    assign tck_rise = p.sync[jip_pkg::SY_TCK] & ~st_q.tck_prev;
    assign tck_fall = ~p.sync[jip_pkg::SY_TCK] & st_q.tck_prev;

    // ------------------------------------------------------------
    // Scan controller transitions
    // ------------------------------------------------------------
    function automatic jip_pkg::jip_tap_e tap_next(
        input jip_pkg::jip_tap_e s,
        input logic              tms
    );
        case (s)
            jip_pkg::TAP_RESET:  tap_next = tms ? jip_pkg::TAP_RESET
                                                : jip_pkg::TAP_IDLE;
            jip_pkg::TAP_IDLE:   tap_next = tms ? jip_pkg::TAP_SEL_DR
                                                : jip_pkg::TAP_IDLE;
            jip_pkg::TAP_SEL_DR: tap_next = tms ? jip_pkg::TAP_SEL_IR
                                                : jip_pkg::TAP_CAP_DR;
            jip_pkg::TAP_CAP_DR: tap_next = tms ? jip_pkg::TAP_EX1_DR
                                                : jip_pkg::TAP_SH_DR;
            jip_pkg::TAP_SH_DR:  tap_next = tms ? jip_pkg::TAP_EX1_DR
                                                : jip_pkg::TAP_SH_DR;
            jip_pkg::TAP_EX1_DR: tap_next = tms ? jip_pkg::TAP_UPD_DR
                                                : jip_pkg::TAP_PAU_DR;
            jip_pkg::TAP_PAU_DR: tap_next = tms ? jip_pkg::TAP_EX2_DR
                                                : jip_pkg::TAP_PAU_DR;
            jip_pkg::TAP_EX2_DR: tap_next = tms ? jip_pkg::TAP_UPD_DR
                                                : jip_pkg::TAP_SH_DR;
            jip_pkg::TAP_UPD_DR: tap_next = tms ? jip_pkg::TAP_SEL_DR
                                                : jip_pkg::TAP_IDLE;
            jip_pkg::TAP_SEL_IR: tap_next = tms ? jip_pkg::TAP_RESET
                                                : jip_pkg::TAP_CAP_IR;
            jip_pkg::TAP_CAP_IR: tap_next = tms ? jip_pkg::TAP_EX1_IR
                                                : jip_pkg::TAP_SH_IR;
            jip_pkg::TAP_SH_IR:  tap_next = tms ? jip_pkg::TAP_EX1_IR
                                                : jip_pkg::TAP_SH_IR;
            jip_pkg::TAP_EX1_IR: tap_next = tms ? jip_pkg::TAP_UPD_IR
                                                : jip_pkg::TAP_PAU_IR;
            jip_pkg::TAP_PAU_IR: tap_next = tms ? jip_pkg::TAP_EX2_IR
                                                : jip_pkg::TAP_PAU_IR;
            jip_pkg::TAP_EX2_IR: tap_next = tms ? jip_pkg::TAP_UPD_IR
                                                : jip_pkg::TAP_SH_IR;
            jip_pkg::TAP_UPD_IR: tap_next = tms ? jip_pkg::TAP_SEL_DR
                                                : jip_pkg::TAP_IDLE;
            default:             tap_next = jip_pkg::TAP_RESET;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.tck_prev = p.sync[jip_pkg::SY_TCK];
        if (!jtag_on) begin
            // Pins are general I/O; hold the scan controller in reset
            st_d.tap    = jip_pkg::TAP_RESET;
            st_d.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            case (st_q.tap)
                jip_pkg::TAP_RESET: begin
                    st_d.ir = jip_pkg::IR_BYPASS;
                end
                jip_pkg::TAP_CAP_IR: begin
                    st_d.ir_sh = jip_pkg::IR_CAPTURE;
                end
                jip_pkg::TAP_SH_IR: begin
                    st_d.ir_sh = {p.sync[jip_pkg::SY_TDI], st_q.ir_sh[3:1]};
                end
                jip_pkg::TAP_UPD_IR: begin
                    st_d.ir = st_q.ir_sh;
                    if (st_q.ir_sh == jip_pkg::IR_EXT_ON) begin
                        st_d.ext_en = 1'b1;
                    end else if (st_q.ir_sh == jip_pkg::IR_EXT_OFF) begin
                        st_d.ext_en = 1'b0;
                    end
                end
                // Every data register path is the one-bit bypass stage
                jip_pkg::TAP_CAP_DR: begin
                    st_d.byp = 1'b0;
                end
                jip_pkg::TAP_SH_DR: begin
                    st_d.byp = p.sync[jip_pkg::SY_TDI];
                end
                default: begin
                end
            endcase
            st_d.tap = tap_next(st_q.tap, p.sync[jip_pkg::SY_TMS]);
        end else if (tck_fall) begin
            st_d.tdo_oe = (st_q.tap == jip_pkg::TAP_SH_IR) ||
                          (st_q.tap == jip_pkg::TAP_SH_DR);
            st_d.tdo    = (st_q.tap == jip_pkg::TAP_SH_IR) ? st_q.ir_sh[0]
                                                           : st_q.byp;
        end

        // Flash progress and fault tracking
        st_d.prog      = ~flash_busy;
        st_d.busy_prev = flash_busy;
        if (flash_error) begin
            st_d.fault = 1'b1;
        end else if (flash_busy && !st_q.busy_prev) begin
            st_d.fault = 1'b0;
        end
        st_d.jtag_prev = jtag_on;

        // Register reads; data valid for one cycle only
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == jip_pkg::REG_CTRL) begin
                st_d.rdata = {5'h00, st_q.ctrl};
            end else if (reg_addr == jip_pkg::REG_STAT) begin
                st_d.rdata = {4'h0, st_q.stat};
                st_d.stat  = jip_pkg::STAT_RST;
            end else if (reg_addr == jip_pkg::REG_MASK) begin
                st_d.rdata = {4'h0, st_q.mask};
            end else begin
                st_d.rdata = {3'h0, st_q.fault, st_q.prog, ext_active,
                              st_q.ext_en, jtag_on};
            end
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == jip_pkg::REG_CTRL) begin
                st_d.ctrl = reg_wdata[2:0];
            end else if (reg_addr == jip_pkg::REG_MASK) begin
                st_d.mask = reg_wdata[3:0];
            end
        end

        events = 4'h0;
        events[jip_pkg::ST_JTAG_UP] = jtag_on & ~st_q.jtag_prev;
        events[jip_pkg::ST_EXT_CHG] = st_d.ext_en ^ st_q.ext_en;
        events[jip_pkg::ST_FAULT]   = flash_error;
        events[jip_pkg::ST_DONE]    = ~flash_busy & st_q.busy_prev;

        // A new event beats a read-clear in the same cycle
        st_d.stat = st_d.stat | events;
    end

    // Synchronous reset also drops the software enable bit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= CORE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_q.rdata;
    assign irq       = |(st_q.stat & st_q.mask);

    assign p.ext_val[jip_pkg::EX_PROG]  = st_q.prog;
    assign p.ext_val[jip_pkg::EX_FAULT] = ~st_q.fault;
    assign p.ext_od[jip_pkg::EX_PROG]   = ~st_q.ctrl[jip_pkg::CTRL_PROG_PP];
    assign p.ext_od[jip_pkg::EX_FAULT]  = ~st_q.ctrl[jip_pkg::CTRL_FAULT_PP];
    assign p.ext_en = {2{ext_active}};
    assign p.gp_o   = {gpio_out[jip_pkg::GP_FAULT], gpio_out[jip_pkg::GP_PROG]};
    assign p.gp_oe  = {gpio_oe[jip_pkg::GP_FAULT], gpio_oe[jip_pkg::GP_PROG]};

    assign port_c_bit0_out = jtag_on ? 1'b0 : gpio_out[jip_pkg::GP_TMS];
    assign port_c_bit0_oe  = jtag_on ? 1'b0 : gpio_oe[jip_pkg::GP_TMS];
    assign port_c_bit1_out = jtag_on ? 1'b0 : gpio_out[jip_pkg::GP_TCK];
    assign port_c_bit1_oe  = jtag_on ? 1'b0 : gpio_oe[jip_pkg::GP_TCK];
    assign port_c_bit5_out = jtag_on ? 1'b0 : gpio_out[jip_pkg::GP_TDI];
    assign port_c_bit5_oe  = jtag_on ? 1'b0 : gpio_oe[jip_pkg::GP_TDI];
    assign port_c_bit6_out = jtag_on ? st_q.tdo : gpio_out[jip_pkg::GP_TDO];
    assign port_c_bit6_oe  = jtag_on ? st_q.tdo_oe : gpio_oe[jip_pkg::GP_TDO];
    assign port_c_bit3_out = p.pin_o[jip_pkg::EX_PROG];
    assign port_c_bit3_oe  = p.pin_oe[jip_pkg::EX_PROG];
    assign port_c_bit4_out = p.pin_o[jip_pkg::EX_FAULT];
    assign port_c_bit4_oe  = p.pin_oe[jip_pkg::EX_FAULT];

    // Raw levels; the user logic samples them in its own domain
    assign gpio_in = {port_c_bit6_in, port_c_bit5_in, port_c_bit4_in,
                      port_c_bit3_in, port_c_bit1_in, port_c_bit0_in};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_ext_cmd;
        tck_rise && jtag_on && (st_q.tap == jip_pkg::TAP_UPD_IR) &&
        (st_q.ir_sh == jip_pkg::IR_EXT_ON);
    endsequence

    sequence s_shift_fall;
        jtag_on && tck_fall && (st_q.tap == jip_pkg::TAP_SH_DR);
    endsequence

    AST_SW_ENABLE: assert property (
        reg_wr && (reg_addr == jip_pkg::REG_CTRL) && reg_wdata[0] |=> jtag_on)
        else $error("software enable did not turn the pins to JTAG");
    AST_DEDICATED: assert property (
        cfg_dedicated_jtag |-> jtag_on && !port_c_bit0_oe &&
        !port_c_bit1_oe && !port_c_bit5_oe)
        else $error("dedicated JTAG pins were driven as I/O");
    AST_RECLAIM: assert property (
        (cfg_reclaim_sel && !cable_reclaim_enable_n) [*3] |-> jtag_on)
        else $error("reclaim input did not return pins to JTAG");
    AST_RESET_CLEAR: assert property (
        @(posedge clk) disable iff (1'b0)
        !rstn |=> !st_q.ctrl[jip_pkg::CTRL_JTAG_EN])
        else $error("reset left the software enable set");
    AST_EXT_CMD: assert property (
        s_ext_cmd ##1 jtag_on |-> ext_active && p.ext_en == 2'b11)
        else $error("extension command did not enable the pair");
    AST_EXT_ONLY_CMD: assert property (
        $rose(st_q.ext_en) |-> $past(tck_rise &&
        (st_q.tap == jip_pkg::TAP_UPD_IR) &&
        (st_q.ir_sh == jip_pkg::IR_EXT_ON)))
        else $error("extension enabled without a scan command");
    AST_FAULT_LOW: assert property (
        flash_error ##1 ext_active |-> port_c_bit4_oe && !port_c_bit4_out)
        else $error("fault pin not driven low after an error");
    AST_PROGRESS: assert property (
        flash_busy ##1 ext_active |-> port_c_bit3_oe && !port_c_bit3_out)
        else $error("progress pin not low during program or erase");
    AST_OPEN_DRAIN: assert property (
        ext_active && !st_q.ctrl[jip_pkg::CTRL_PROG_PP] |->
        !port_c_bit3_out && (port_c_bit3_oe == !st_q.prog))
        else $error("open-drain progress pin drove high");
    AST_BLANK: assert property (
        !cfg_programmed |-> jtag_on)
        else $error("blank part did not enable the JTAG pins");
    AST_GPIO: assert property (
        !jtag_on |-> port_c_bit6_oe == gpio_oe[jip_pkg::GP_TDO] &&
        port_c_bit0_out == gpio_out[jip_pkg::GP_TMS])
        else $error("JTAG pins not under general I/O control");
    AST_BYPASS: assert property (
        s_shift_fall ##1 jtag_on |->
        port_c_bit6_oe && port_c_bit6_out == $past(st_q.byp))
        else $error("shift-DR output is not the bypass bit");
    AST_EXT_IDLE: assert property (
        !ext_active |-> port_c_bit4_oe == gpio_oe[jip_pkg::GP_FAULT] &&
        port_c_bit3_out == gpio_out[jip_pkg::GP_PROG])
        else $error("extension pins driven without the command");
endmodule

// file: jip_host.sv
`timescale 1ns/100ps
module jip_host (
    // Link pins toward the device
    output logic tck,
    output logic tms,
    output logic tdi,
    // Reclaim line into the dedicated PLD input
    output logic cable_reclaim_enable_n
);
    // One bit per 400 ns period; TCK rests low between frames
    task automatic step(input logic m, input logic v);
        tms = m;
        tdi = v;
        #200 tck = 1'b1;
        #200 tck = 1'b0;
    endtask

    // Reset the controller, walk to Shift-IR, load the code LSB first
    task automatic load_ir(input logic [3:0] code);
        for (int i = 0; i < 5; i++) step(1'b1, 1'b0);
        for (int i = 0; i < 5; i++) step(5'h06 >> i, 1'b0);
        for (int i = 0; i < 4; i++) step(i == 3, code[i]);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        // Released data line must not look like a held value
        tdi = ~tdi;
    endtask

    // Cable pulls the pins back for programming
    task automatic grab(input logic on);
        cable_reclaim_enable_n = ~on;
    endtask

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        cable_reclaim_enable_n = 1'b1;
    end
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
    logic       clk, rstn, reg_wr, reg_rd, irq, jtag_on, p0o, p0e;
    logic       cfg_programmed, cfg_dedicated_jtag, cfg_reclaim_sel;
    logic       pld_jtag_eq, flash_busy, flash_error, p3o, p3e, p4o, p4e;
    logic       tck, tms, tdi, cable_reclaim_enable_n, p6o, p6e;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [5:0] gpio_out, gpio_oe, gpio_in;
    int         miscompares, num_checks;

    always #25 clk = ~clk;

    jip_host jip_host_inst (.tck, .tms, .tdi, .cable_reclaim_enable_n);
    jip_top jip_top_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .cfg_programmed, .cfg_dedicated_jtag,
        .cfg_reclaim_sel, .pld_jtag_eq, .cable_reclaim_enable_n,
        .flash_busy, .flash_error, .gpio_out, .gpio_oe, .gpio_in, .jtag_on,
        .port_c_bit0_in(tms), .port_c_bit0_out(p0o), .port_c_bit0_oe(p0e),
        .port_c_bit1_in(tck), .port_c_bit1_out(), .port_c_bit1_oe(),
        .port_c_bit3_in(1'b1), .port_c_bit3_out(p3o), .port_c_bit3_oe(p3e),
        .port_c_bit4_in(1'b1), .port_c_bit4_out(p4o), .port_c_bit4_oe(p4e),
        .port_c_bit5_in(tdi), .port_c_bit5_out(), .port_c_bit5_oe(),
        .port_c_bit6_in(1'b1), .port_c_bit6_out(p6o), .port_c_bit6_oe(p6e));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic t_src;
        jip_host_inst.grab(1'b1);
        for (int i = 0; i < 3; i++) begin
            {cfg_dedicated_jtag, pld_jtag_eq, cfg_reclaim_sel} <= 3'h1 << i;
            tick(5);
            check(jtag_on, 1'b1);
            {cfg_dedicated_jtag, pld_jtag_eq, cfg_reclaim_sel} <= 3'h0;
            tick(5);
            check({p0o, p0e}, 2'h1);
        end
        rd(jip_pkg::REG_STAT);
        wr(jip_pkg::REG_MASK, 8'h01);
        tick(1);
        check(irq, 1'b0);
        wr(jip_pkg::REG_CTRL, 8'h01);
        tick(2);
        check({irq, jtag_on}, 2'h3);
        rd(jip_pkg::REG_STAT);
        check(d[0], 1'b1);
        check(irq, 1'b0);
        rstn <= 1'b0;
        tick(1);
        rstn <= 1'b1;
        tick(1);
        check(jtag_on, 1'b0);
        $display("t_src done");
    endtask

    task automatic t_ext;
        cfg_dedicated_jtag <= 1'b1;
        tick(2);
        check({p3o, p3e, p4o, p4e}, 4'h6);
        jip_host_inst.load_ir(jip_pkg::IR_EXT_ON);
        tick(4);
        check({p3o, p3e, p4o, p4e}, 4'h0);
        rd(jip_pkg::REG_STATE);
        check(d, 8'h0F);
        flash_busy <= 1'b1;
        tick(2);
        check({p3o, p3e}, 2'h1);
        flash_error <= 1'b1;
        tick(1);
        flash_error <= 1'b0;
        tick(2);
        check({p4o, p4e}, 2'h1);
        wr(jip_pkg::REG_CTRL, 8'h06);
        flash_busy <= 1'b0;
        tick(3);
        check({p3o, p3e, p4o, p4e}, 4'hD);
        jip_host_inst.load_ir(jip_pkg::IR_EXT_OFF);
        tick(4);
        check({p3o, p3e, p4o, p4e}, 4'h6);
        jip_host_inst.step(1'b1, 1'b0);
        jip_host_inst.step(1'b0, 1'b0);
        jip_host_inst.step(1'b0, 1'b1);
        tick(4);
        check({p6o, p6e}, 2'h1);
        jip_host_inst.step(1'b0, 1'b1);
        tick(4);
        check({p6o, p6e}, 2'h3);
        jip_host_inst.step(1'b1, 1'b0);
        tick(4);
        check({p6o, p6e}, 2'h0);
        $display("t_ext done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        miscompares++;
        results;
    end

    initial begin
        {clk, rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {cfg_programmed, cfg_dedicated_jtag, cfg_reclaim_sel} = 3'h0;
        {pld_jtag_eq, flash_busy, flash_error} = 3'h0;
        gpio_out = 6'h2A;
        gpio_oe = 6'h15;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        tick(1);
        check(jtag_on, 1'b1);
        check(gpio_in, 8'h2D);
        rd(jip_pkg::REG_CTRL);
        check(d, 8'h00);
        cfg_programmed <= 1'b1;
        tick(2);
        check({jtag_on, p0o, p0e}, 3'h1);
        t_src;
        t_ext;
        results;
    end
endmodule
